// ---- logic/gcs_global_regs.sv ----
// Global configuration and status register bank of a two-axis motion controller
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps

module gcs_global_regs #(
  parameter int POS_WIDTH = 32
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register port
  input  gcs_pkg::gcs_bus_req_t     bus_req,
  output logic [31:0]               rdata,
  // Driver events and levels
  input  gcs_pkg::gcs_events_t      events,
  input  wire logic                 irq_level,
  // Motion inputs
  input  wire logic [POS_WIDTH-1:0] actual_position_m1,
  input  wire logic                 motor1_dir_raw,
  input  wire logic                 motor2_dir_raw,
  // Motion outputs
  output logic                      motor1_dir,
  output logic                      motor2_dir,
  output logic                      driver_enable,
  // Pins
  output gcs_pkg::gcs_pin_t         position_pulse_out,
  output gcs_pkg::gcs_pin_t         interrupt_out
);
  import gcs_pkg::*;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [GCS_CFG_WIDTH-1:0]  global_config_reg;
  logic [POS_WIDTH-1:0]      position_compare_value_reg;
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;
  logic [GCS_STAT_WIDTH-1:0] global_status;
  logic [GCS_STAT_WIDTH-1:0] status_set;
  logic                      status_rd;
  logic                      pos_match;
  logic                      config_write_lock;
  logic                      compare_output_enable;

  assign config_write_lock     = global_config_reg[GCS_CFG_LOCK_BIT];
  assign compare_output_enable = global_config_reg[GCS_CFG_CMP_OE_BIT];
  assign status_rd             = bus_req.rd && (bus_req.addr == GCS_ADDR_GLOBAL_STATUS);

  // Configuration write, blocked once locked; only reset unlocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_config_reg <= GCS_CFG_RESET;
    end else if (bus_req.wr && bus_req.addr == GCS_ADDR_GLOBAL_CONFIG && !config_write_lock) begin
      global_config_reg <= bus_req.wdata[GCS_CFG_WIDTH-1:0];
    end
  end

  // Compare value write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      position_compare_value_reg <= POS_WIDTH'(GCS_CMP_RESET);
    end else if (bus_req.wr && bus_req.addr == GCS_ADDR_POS_COMPARE_M1) begin
      position_compare_value_reg <= bus_req.wdata[POS_WIDTH-1:0];
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always_comb begin
    status_set                     = '0;
    status_set[GCS_STAT_DRV1_BIT]  = events.drv1_shutdown;
    status_set[GCS_STAT_DRV2_BIT]  = events.drv2_shutdown;
    status_set[GCS_STAT_UV_BIT]    = events.pump_uv;
  end

  // Clear on read of the status register
  gcs_sticky_flags #(
    .WIDTH (GCS_STAT_WIDTH)
  ) u_flags (
    .clk    (clk),
    .rst    (rst),
    .set_in (status_set),
    .clear  (status_rd),
    .flags  (global_status)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_next = GCS_ZERO_WORD;
    if (bus_req.rd) begin
      case (bus_req.addr)
        GCS_ADDR_GLOBAL_CONFIG: rdata_next[GCS_CFG_WIDTH-1:0]  = global_config_reg;
        GCS_ADDR_GLOBAL_STATUS: rdata_next[GCS_STAT_WIDTH-1:0] = global_status;
        GCS_ADDR_ACTUAL_POS_M1: rdata_next[POS_WIDTH-1:0]      = actual_position_m1;
        default:                rdata_next = GCS_ZERO_WORD;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= GCS_ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // ****************************************************************
  // Motion control outputs
  // ****************************************************************
  always_comb begin
    motor1_dir    = motor1_dir_raw ^ global_config_reg[GCS_CFG_M1_INV_BIT];
    motor2_dir    = motor2_dir_raw ^ global_config_reg[GCS_CFG_M2_INV_BIT];
    driver_enable = !events.pump_uv;
  end

  // Comparator and pins
  gcs_pos_compare #(
    .POS_WIDTH (POS_WIDTH)
  ) u_cmp (
    .clk         (clk),
    .rst         (rst),
    .actual_pos  (actual_position_m1),
    .compare_val (position_compare_value_reg),
    .out_enable  (compare_output_enable),
    .irq_level   (irq_level),
    .pulse_pin   (position_pulse_out),
    .irq_pin     (interrupt_out),
    .match       (pos_match)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_lock;
    @(posedge clk) disable iff (rst)
    config_write_lock |=> $stable(global_config_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked config changed");

  property p_lock_hold;
    @(posedge clk) disable iff (rst)
    config_write_lock |=> config_write_lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");

  property p_rd_clear;
    @(posedge clk) disable iff (rst)
    (status_rd && !events.drv1_shutdown) |=> !global_status[GCS_STAT_DRV1_BIT];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("status not cleared");

  property p_drv2_set;
    @(posedge clk) disable iff (rst)
    events.drv2_shutdown |=> global_status[GCS_STAT_DRV2_BIT];
  endproperty
  a_drv2_set: assert property (p_drv2_set) else $error("driver 2 fault lost");

  property p_reset_hold;
    @(posedge clk) disable iff (rst)
    (global_status[GCS_STAT_RESET_BIT] && !status_rd) |=> global_status[GCS_STAT_RESET_BIT];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset flag lost");

  property p_uv;
    @(posedge clk) disable iff (rst)
    events.pump_uv |-> (!driver_enable ##1 global_status[GCS_STAT_UV_BIT]);
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not handled");

  sequence s_equal;
    actual_position_m1 == position_compare_value_reg;
  endsequence
  property p_pulse;
    @(posedge clk) disable iff (rst)
    s_equal |=> position_pulse_out.o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse missing on match");

  property p_no_pulse;
    @(posedge clk) disable iff (rst)
    (actual_position_m1 != position_compare_value_reg) |=> !pos_match;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("pulse on mismatch");

  property p_oe;
    @(posedge clk) disable iff (rst)
    position_pulse_out.oe == compare_output_enable && interrupt_out.oe == position_pulse_out.oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");

  property p_dir;
    @(posedge clk) disable iff (rst)
    (motor1_dir != motor1_dir_raw) == global_config_reg[GCS_CFG_M1_INV_BIT]
      && (motor2_dir != motor2_dir_raw) == global_config_reg[GCS_CFG_M2_INV_BIT];
  endproperty
  a_dir: assert property (p_dir) else $error("direction invert wrong");

  // ****************************************************************
  // Assertions: register port and flag detail
  // ****************************************************************
  // Write data as it lands in the narrower registers
  logic [GCS_CFG_WIDTH-1:0] cfg_wdata;
  logic [POS_WIDTH-1:0]     cmp_wdata;
  assign cfg_wdata = bus_req.wdata[GCS_CFG_WIDTH-1:0];
  assign cmp_wdata = bus_req.wdata[POS_WIDTH-1:0];

  // Configuration write while the lock is still open
  sequence s_cfg_write;
    bus_req.wr && bus_req.addr == GCS_ADDR_GLOBAL_CONFIG && !config_write_lock;
  endsequence

  // Status read with no driver event in the same cycle
  sequence s_quiet_status_read;
    status_rd && status_set == '0;
  endsequence

  property p_cfg_write;
    @(posedge clk) disable iff (rst)
    s_cfg_write |=> global_config_reg == $past(cfg_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("open config write lost");

  property p_cfg_locked;
    @(posedge clk) disable iff (rst)
    (bus_req.wr && bus_req.addr == GCS_ADDR_GLOBAL_CONFIG && config_write_lock) |=> config_write_lock;
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("write broke the lock");

  property p_cmp_write;
    @(posedge clk) disable iff (rst)
    (bus_req.wr && bus_req.addr == GCS_ADDR_POS_COMPARE_M1) |=> position_compare_value_reg == $past(cmp_wdata);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("compare value write lost");

  property p_status_read;
    @(posedge clk) disable iff (rst)
    status_rd |=> rdata[GCS_STAT_WIDTH-1:0] == $past(global_status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong");

  property p_status_clear;
    @(posedge clk) disable iff (rst)
    s_quiet_status_read |=> global_status == '0;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");

  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
    !bus_req.rd |=> rdata == GCS_ZERO_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle"); // Read port

  property p_drv1_set;
    @(posedge clk) disable iff (rst)
    events.drv1_shutdown |=> global_status[GCS_STAT_DRV1_BIT];
  endproperty
  a_drv1_set: assert property (p_drv1_set) else $error("driver 1 fault lost");

  property p_drv1_hold;
    @(posedge clk) disable iff (rst)
    (global_status[GCS_STAT_DRV1_BIT] && !status_rd) |=> global_status[GCS_STAT_DRV1_BIT];
  endproperty
  a_drv1_hold: assert property (p_drv1_hold) else $error("driver 1 fault dropped");

  property p_drv2_hold;
    @(posedge clk) disable iff (rst)
    (global_status[GCS_STAT_DRV2_BIT] && !status_rd) |=> global_status[GCS_STAT_DRV2_BIT];
  endproperty
  a_drv2_hold: assert property (p_drv2_hold) else $error("driver 2 fault dropped");

  property p_drv2_clear;
    @(posedge clk) disable iff (rst)
    (status_rd && !events.drv2_shutdown) |=> !global_status[GCS_STAT_DRV2_BIT];
  endproperty
  a_drv2_clear: assert property (p_drv2_clear) else $error("driver 2 fault not cleared");

  property p_uv_hold;
    @(posedge clk) disable iff (rst)
    (global_status[GCS_STAT_UV_BIT] && !status_rd) |=> global_status[GCS_STAT_UV_BIT];
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("undervoltage flag dropped");

  property p_uv_clear;
    @(posedge clk) disable iff (rst)
    (status_rd && !events.pump_uv) |=> !global_status[GCS_STAT_UV_BIT];
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("undervoltage flag not cleared");

  property p_irq_drive;
    @(posedge clk) disable iff (rst)
    compare_output_enable |-> (interrupt_out.oe && interrupt_out.o == irq_level);
  endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("interrupt pin not driven");

endmodule : gcs_global_regs

// ---- logic/gcs_pkg.sv ----
// Package with register map, field layout and carrier types of the global config/status bank
package gcs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [6:0] GCS_ADDR_GLOBAL_CONFIG  = 7'h00;
  localparam logic [6:0] GCS_ADDR_GLOBAL_STATUS  = 7'h01;
  localparam logic [6:0] GCS_ADDR_POS_COMPARE_M1 = 7'h05;
  localparam logic [6:0] GCS_ADDR_ACTUAL_POS_M1  = 7'h21; // Read-back of motor 1 position

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int GCS_CFG_WIDTH        = 11;
  localparam int GCS_STAT_WIDTH       = 4;
  localparam int GCS_CFG_CMP_OE_BIT   = 0;
  localparam int GCS_CFG_M1_INV_BIT   = 8;
  localparam int GCS_CFG_M2_INV_BIT   = 9;
  localparam int GCS_CFG_LOCK_BIT     = 10;
  localparam int GCS_STAT_RESET_BIT   = 0;
  localparam int GCS_STAT_DRV1_BIT    = 1;
  localparam int GCS_STAT_DRV2_BIT    = 2;
  localparam int GCS_STAT_UV_BIT      = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [GCS_CFG_WIDTH-1:0]  GCS_CFG_RESET  = 11'h000;
  localparam logic [GCS_STAT_WIDTH-1:0] GCS_STAT_RESET = 4'h1;
  localparam logic [31:0]               GCS_CMP_RESET  = 32'h0000_0000;
  localparam logic [31:0]               GCS_ZERO_WORD  = 32'h0000_0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [6:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gcs_bus_req_t;

  typedef struct packed {
    logic drv1_shutdown;
    logic drv2_shutdown;
    logic pump_uv;
  } gcs_events_t;

  typedef struct packed {
    logic o;
    logic oe;
  } gcs_pin_t;

endpackage : gcs_pkg

// ---- logic/gcs_sticky_flags.sv ----
// Sticky clear-on-read status flags
`timescale 1ns/10ps
module gcs_sticky_flags #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Event inputs and read-clear
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic             clear,
  // Flag state
  output logic      [WIDTH-1:0] flags
);
  import gcs_pkg::*;

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // Set wins over clear in the same cycle
  always_comb begin
    flags_next = (clear ? '0 : flags_reg) | set_in;
  end

  // Flag storage; reset-seen flag comes up set after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= WIDTH'(GCS_STAT_RESET);
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : gcs_sticky_flags

// ---- logic/gcs_pos_compare.sv ----
// Motor 1 position comparator with tristate-able pulse and interrupt pins
`timescale 1ns/10ps
module gcs_pos_compare #(
  parameter int POS_WIDTH = 32
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Compare operands
  input  wire logic [POS_WIDTH-1:0] actual_pos,
  input  wire logic [POS_WIDTH-1:0] compare_val,
  input  wire logic                 out_enable,
  input  wire logic                 irq_level,
  // Pins
  output gcs_pkg::gcs_pin_t         pulse_pin,
  output gcs_pkg::gcs_pin_t         irq_pin,
  output logic                      match
);
  import gcs_pkg::*;

  logic match_reg;

  // Registered equality, high in the cycle after the positions agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= (actual_pos == compare_val);
    end
  end

  // Pins driven only while the output enable is set
  always_comb begin
    pulse_pin.o  = match_reg;
    pulse_pin.oe = out_enable;
    irq_pin.o    = irq_level;
    irq_pin.oe   = out_enable;
  end

  assign match = match_reg;

endmodule : gcs_pos_compare

// ---- bench/gcs_host_model.sv ----
// Host controller model: register port master and board pull-ups on the compare pins
`timescale 1ns/10ps
module gcs_host_model (
  // Clock
  input  wire logic             clk,
  // Register port
  output gcs_pkg::gcs_bus_req_t bus_req,
  input  wire logic [31:0]      rdata,
  // Compare pins and board levels
  input  wire gcs_pkg::gcs_pin_t pulse_pin,
  input  wire gcs_pkg::gcs_pin_t irq_pin,
  output logic                  pulse_level,
  output logic                  irq_wire
);
  import gcs_pkg::*;
  // ****************************************************************
  // Board wiring
  // ****************************************************************
  // Pull-ups keep tristated outputs from floating
  assign pulse_level = pulse_pin.oe ? pulse_pin.o : 1'b1;
  assign irq_wire    = irq_pin.oe ? irq_pin.o : 1'b1;
  initial bus_req = '0;
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // One-cycle write strobe
  task automatic write_reg(input logic [6:0] addr, input logic [31:0] data);
    @(posedge clk);
    bus_req <= {addr, data, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : write_reg
  // One-cycle read strobe, data taken in the following cycle
  task automatic read_reg(input logic [6:0] addr, output logic [31:0] data);
    @(posedge clk);
    bus_req <= {addr, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    data = rdata;
  endtask : read_reg
  // Write strobe followed with no gap by a read strobe of the same register
  task automatic write_read(input logic [6:0] addr, input logic [31:0] wdata, output logic [31:0] data);
    @(posedge clk);
    bus_req <= {addr, wdata, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= {addr, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    data = rdata;
  endtask : write_read
endmodule : gcs_host_model

// ---- bench/gcs_global_regs_tb_top.sv ----
// Self-checking testbench of the global config/status register bank
`timescale 1ns/10ps
module gcs_global_regs_tb_top;
  import gcs_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  gcs_bus_req_t  bus_req;
  logic [31:0]   rdata;
  gcs_events_t   events = '0;
  logic          irq_level = 1'b1;
  logic [31:0]   actual_position_m1 = 32'h0000_0007;
  logic          motor1_dir_raw = 1'b0;
  logic          motor2_dir_raw = 1'b0;
  logic          motor1_dir, motor2_dir, driver_enable, pulse_level, irq_wire;
  gcs_pin_t      pulse_pin, irq_pin;
  logic [31:0]   d;
  int            bad_count = 0;
  int            n_tests = 0;
  int            cycles = 0;
  // Clock
  always #4 clk = ~clk;
  // ****************************************************************
  // Design and host
  // ****************************************************************
  gcs_global_regs #(.POS_WIDTH(32)) dut (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .events(events), .irq_level(irq_level), .actual_position_m1(actual_position_m1),
    .motor1_dir_raw(motor1_dir_raw), .motor2_dir_raw(motor2_dir_raw), .motor1_dir(motor1_dir),
    .motor2_dir(motor2_dir), .driver_enable(driver_enable), .position_pulse_out(pulse_pin),
    .interrupt_out(irq_pin));
  gcs_host_model host (.clk(clk), .bus_req(bus_req), .rdata(rdata), .pulse_pin(pulse_pin),
    .irq_pin(irq_pin), .pulse_level(pulse_level), .irq_wire(irq_wire));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic ev_read(input gcs_events_t e, output logic [31:0] data);
    @(posedge clk);
    events <= e;
    @(posedge clk);
    events <= '0;
    host.read_reg(GCS_ADDR_GLOBAL_STATUS, data);
  endtask : ev_read
  // Timeout guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_flag();
    host.read_reg(GCS_ADDR_GLOBAL_STATUS, d);
    check(d, 32'h0000_0001, "reset flag after reset");
    host.read_reg(GCS_ADDR_GLOBAL_STATUS, d);
    check(d, 32'h0000_0000, "reset flag after read");
  endtask : t_reset_flag
  task automatic t_pins();
    check({pulse_pin.oe, irq_pin.oe, pulse_level, irq_wire}, 4'h3, "pins floating");
    @(posedge clk);
    irq_level <= 1'b0;
    host.write_reg(GCS_ADDR_GLOBAL_CONFIG, 32'h0000_0001);
    @(negedge clk);
    check({pulse_pin.oe, irq_pin.oe, pulse_level, irq_wire}, 4'hC, "pins driven");
    @(posedge clk);
    irq_level <= 1'b1;
  endtask : t_pins
  task automatic t_dir();
    for (int c = 0; c < 4; c++) begin
      host.write_reg(GCS_ADDR_GLOBAL_CONFIG, {21'h0, 1'b0, c[1:0], 8'h01});
      for (int r = 0; r < 4; r++) begin
        @(posedge clk);
        {motor2_dir_raw, motor1_dir_raw} <= r[1:0];
        @(negedge clk);
        check(motor1_dir, r[0] ^ c[0], "motor 1 direction");
        check(motor2_dir, r[1] ^ c[1], "motor 2 direction");
      end
    end
  endtask : t_dir
  task automatic t_compare();
    host.write_reg(GCS_ADDR_POS_COMPARE_M1, 32'h8000_0001);
    @(negedge clk);
    check(pulse_level, 1'b0, "pulse low on mismatch");
    @(posedge clk);
    actual_position_m1 <= 32'h8000_0001;
    @(posedge clk);
    @(negedge clk);
    check(pulse_level, 1'b1, "pulse high on match");
    @(posedge clk);
    actual_position_m1 <= 32'h8000_0000;
    @(posedge clk);
    @(negedge clk);
    check(pulse_level, 1'b0, "pulse low after match");
    host.read_reg(GCS_ADDR_POS_COMPARE_M1, d);
    check(d, 32'h0000_0000, "compare register reads zero");
    host.read_reg(GCS_ADDR_ACTUAL_POS_M1, d);
    check(d, 32'h8000_0000, "actual position read-back");
  endtask : t_compare
  task automatic t_events();
    ev_read({1'b1, 1'b0, 1'b0}, d);
    check(d, 32'h0000_0002, "driver 1 fault");
    ev_read({1'b0, 1'b1, 1'b0}, d);
    check(d, 32'h0000_0004, "driver 2 fault");
    @(posedge clk);
    events.pump_uv <= 1'b1;
    @(negedge clk);
    check(driver_enable, 1'b0, "driver held off");
    ev_read({1'b0, 1'b0, 1'b1}, d);
    check(d, 32'h0000_0008, "pump undervoltage");
    check(driver_enable, 1'b1, "driver enabled again");
    host.read_reg(GCS_ADDR_GLOBAL_STATUS, d);
    check(d, 32'h0000_0000, "flags cleared by read");
    // Driver 2 event lands on the very edge that takes the status read
    fork
      host.read_reg(GCS_ADDR_GLOBAL_STATUS, d);
      begin
        @(posedge clk);
        events.drv2_shutdown <= 1'b1;
        @(posedge clk);
        events.drv2_shutdown <= 1'b0;
      end
    join
    check(d, 32'h0000_0000, "read before same-cycle event");
    host.read_reg(GCS_ADDR_GLOBAL_STATUS, d);
    check(d, 32'h0000_0004, "event wins over read-clear");
  endtask : t_events
  task automatic t_lock();
    host.write_read(GCS_ADDR_GLOBAL_CONFIG, 32'h0000_0201, d);
    check(d, 32'h0000_0201, "read straight after open write");
    @(negedge clk);
    check(rdata, 32'h0000_0000, "read data for one cycle only");
    host.write_reg(GCS_ADDR_GLOBAL_CONFIG, 32'h0000_0401);
    host.write_reg(GCS_ADDR_GLOBAL_CONFIG, 32'h0000_0000);
    host.read_reg(GCS_ADDR_GLOBAL_CONFIG, d);
    check(d, 32'h0000_0401, "locked config kept");
    host.write_reg(GCS_ADDR_GLOBAL_CONFIG, 32'h0000_0300);
    host.read_reg(GCS_ADDR_GLOBAL_CONFIG, d);
    check(d, 32'h0000_0401, "lock still held");
    do_reset(3);
    host.read_reg(GCS_ADDR_GLOBAL_CONFIG, d);
    check(d, 32'h0000_0000, "lock gone after reset");
    t_reset_flag();
  endtask : t_lock
  // Main sequence
  initial begin
    do_reset(20);
    t_reset_flag();
    t_pins();
    t_dir();
    t_compare();
    t_events();
    t_lock();
    results();
  end
endmodule : gcs_global_regs_tb_top
